// ---- verilog/cssq_pkg.sv ----
// constants and types shared by the core supply start-up sequencer
package cssq_pkg;
  // clock rate in kHz (40 MHz core clock)
  localparam int CLK_KHZ = 40000;
  // delay from enable to start of the soft-start ramp, in microseconds
  localparam int START_DELAY_US = 100;
  localparam int START_DELAY_CYC = START_DELAY_US * CLK_KHZ / 1000;
  // power-good time from enable, in milliseconds
  localparam int POWER_GOOD_OUT_TIME_MS = 7;
  localparam int POWER_GOOD_OUT_CYC = POWER_GOOD_OUT_TIME_MS * CLK_KHZ;
  // clock-enable release count after the output settles near boot
  localparam int CLK_EN_COUNT = 13;
  localparam logic [3:0] CLK_EN_LAST = 4'(CLK_EN_COUNT - 1);
  // voltages in units of 0.1 mV
  localparam int MV_W = 14;
  localparam logic [13:0] BOOT_MV = 14'h2EE0;    // 1.2000 V
  localparam logic [13:0] NEAR_MV = 14'h00C8;    // 20.0 mV window
  localparam logic [13:0] VID_BASE_MV = 14'h3A98; // 1.5000 V at code 0
  localparam logic [13:0] VID_STEP_MV = 14'h007D; // 12.5 mV per code step
  localparam logic [6:0] VID_ZERO_CODE = 7'h78;  // codes from here up give 0 V
  localparam logic [13:0] ZERO_MV = 14'h0000;
  localparam int ELAPSED_W = 20;
  typedef enum logic [2:0] {
    cssq_idle,
    cssq_delay,
    cssq_ramp,
    cssq_count,
    cssq_slew,
    cssq_run
  } cssq_state_type;
endpackage

// ---- verilog/cssq_vid_decoder.sv ----
// decodes the 7-bit voltage identification code into a target voltage
`timescale 1ns/100ps
module cssq_vid_decoder (
  input wire logic [6:0] voltage_id_code,
  output logic [13:0] vid_target_mv
);
  wire logic [13:0] code_ext;
  wire logic [27:0] step_product;
  wire logic in_range;

  // bit 0 is the least significant bit of the code
  assign code_ext = {7'h00, voltage_id_code};
  assign step_product = code_ext * cssq_pkg::VID_STEP_MV;
  assign in_range = voltage_id_code < cssq_pkg::VID_ZERO_CODE;
  // top eight codes floor at zero volts instead of wrapping negative
  assign vid_target_mv = in_range ? 14'(cssq_pkg::VID_BASE_MV - step_product[13:0]) : cssq_pkg::ZERO_MV;
endmodule

// ---- verilog/cssq_sequencer.sv ----
// start-up sequencer and target selection for the core supply controller
// Functional notes
// R1: start only on enable rising while control supply is above power-on-reset level
// R2: after about 100 us delay, ramp soft-start and output toward 1.2 V boot
// R3: during start-up force continuous conduction; ignore sleep and diode-emulation inputs
// R4: use low soft-start current while ramping to boot voltage
// R5: once output within 20 mV of boot, count 13 clocks, then drive clock-enable low
// R6: with clock-enable asserted use high soft-start current, slewing toward code voltage
// R7: raise power-good about 7 ms after enable, after moving to code voltage
// R8: after start-up the target comes from the 7-bit identification code
// R9: code 0 means 1.5000 V, each step lowers target 12.5 mV
// R10: identification input 0 is least significant, input 6 most significant
// R11: enable low abandons sequence, drops power-good and clock-enable, returns idle
`timescale 1ns/100ps
module cssq_sequencer #(
  parameter int POWER_GOOD_OUT_CYCLES = cssq_pkg::POWER_GOOD_OUT_CYC
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic regulator_enable_in,
  input wire logic supply_above_por,
  input wire logic [13:0] output_voltage_sense,
  input wire logic [6:0] voltage_id_code,
  input wire logic sleep_request,
  input wire logic diode_emulation_request,
  output logic forced_continuous_conduction,
  output logic diode_emulation_en,
  output logic soft_ramp_en,
  output logic soft_current_high,
  output logic [13:0] target_mv,
  output logic clk_enable_b,
  output logic power_good_out
);
  cssq_pkg::cssq_state_type state;
  cssq_pkg::cssq_state_type next_state;
  logic enable_prev;
  logic [19:0] elapsed;
  logic [3:0] settle_count;
  logic [13:0] next_target_mv;
  logic next_clk_enable_b;
  logic next_power_good;
  wire logic [13:0] vid_target_mv;
  wire logic go_on;
  wire logic start_req;
  wire logic near_boot;
  wire logic delay_done;
  wire logic power_good_out_time;
  wire logic settle_done;
  wire logic startup_active;
  wire logic code_phase;

  cssq_vid_decoder u_vid_decoder (
    .voltage_id_code(voltage_id_code),
    .vid_target_mv(vid_target_mv)
  );

  assign go_on = regulator_enable_in && supply_above_por; // [R11]
  assign start_req = regulator_enable_in && !enable_prev && supply_above_por; // [R1]
  assign near_boot = (output_voltage_sense >= 14'(cssq_pkg::BOOT_MV - cssq_pkg::NEAR_MV)) &&
                     (output_voltage_sense <= 14'(cssq_pkg::BOOT_MV + cssq_pkg::NEAR_MV)); // [R5]
  assign delay_done = elapsed == 20'(cssq_pkg::START_DELAY_CYC - 1); // [R2]
  assign power_good_out_time = elapsed >= 20'(POWER_GOOD_OUT_CYCLES - 1); // [R7]
  assign settle_done = settle_count == cssq_pkg::CLK_EN_LAST; // [R5]
  assign startup_active = (state != cssq_pkg::cssq_idle) && (state != cssq_pkg::cssq_run);

  always_comb begin
    next_state = state;
    case (state)
      cssq_pkg::cssq_idle: begin
        if (start_req) begin
          next_state = cssq_pkg::cssq_delay; // [R1]
        end
      end
      cssq_pkg::cssq_delay: begin
        if (delay_done) begin
          next_state = cssq_pkg::cssq_ramp; // [R2]
        end
      end
      cssq_pkg::cssq_ramp: begin
        if (near_boot) begin
          next_state = cssq_pkg::cssq_count; // [R5]
        end
      end
      cssq_pkg::cssq_count: begin
        if (settle_done) begin
          next_state = cssq_pkg::cssq_slew; // [R5]
        end
      end
      cssq_pkg::cssq_slew: begin
        if (power_good_out_time) begin
          next_state = cssq_pkg::cssq_run; // [R7]
        end
      end
      cssq_pkg::cssq_run: begin
        next_state = cssq_pkg::cssq_run;
      end
      default: begin
        next_state = cssq_pkg::cssq_idle;
      end
    endcase
    // losing enable or the control supply wins over every other step
    if (!go_on) begin
      next_state = cssq_pkg::cssq_idle; // [R11]
    end
  end

  // boot level until clock-enable asserts, then the decoded code
  // clock-enable and target share one decode so they can never disagree
  assign code_phase = (next_state == cssq_pkg::cssq_slew) || (next_state == cssq_pkg::cssq_run);
  assign next_clk_enable_b = !code_phase; // [R5] [R11]
  assign next_power_good = next_state == cssq_pkg::cssq_run; // [R7] [R11]
  assign next_target_mv = next_clk_enable_b ? cssq_pkg::BOOT_MV : vid_target_mv; // [R6] [R8]

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= cssq_pkg::cssq_idle;
      enable_prev <= 1'b0;
      clk_enable_b <= 1'b1;
      power_good_out <= 1'b0;
      target_mv <= cssq_pkg::BOOT_MV;
    end else begin
      state <= next_state;
      enable_prev <= regulator_enable_in;
      clk_enable_b <= next_clk_enable_b;
      power_good_out <= next_power_good;
      target_mv <= next_target_mv;
    end
  end

  // elapsed time since enable; saturates so a long run never wraps
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      elapsed <= 20'h00000;
    end else if (state == cssq_pkg::cssq_idle) begin
      elapsed <= 20'h00000;
    end else if (elapsed != 20'hFFFFF) begin
      elapsed <= elapsed + 20'h00001;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      settle_count <= 4'h0;
    end else if (state == cssq_pkg::cssq_count) begin
      settle_count <= settle_count + 4'h1; // [R5]
    end else begin
      settle_count <= 4'h0;
    end
  end

  // sleep and diode-emulation only act once start-up has finished
  assign diode_emulation_en = (state == cssq_pkg::cssq_run) && (sleep_request || diode_emulation_request); // [R3]
  assign forced_continuous_conduction = !diode_emulation_en; // [R3]
  assign soft_ramp_en = (state != cssq_pkg::cssq_idle) && (state != cssq_pkg::cssq_delay); // [R2]
  assign soft_current_high = !clk_enable_b; // [R4] [R6]

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  a_idle_no_start: assert property (state == cssq_pkg::cssq_idle && !start_req |=> state == cssq_pkg::cssq_idle) // [R1]
    else $error("sequence left idle without a qualified enable edge");
  a_delay_length: assert property ($rose(soft_ramp_en) |-> $past(elapsed) == 20'(cssq_pkg::START_DELAY_CYC - 1)) // [R2]
    else $error("ramp started at the wrong delay");
  a_startup_ccm: assert property (startup_active |-> forced_continuous_conduction && !diode_emulation_en) // [R3]
    else $error("continuous conduction not forced during start-up");
  a_low_current_ramp: assert property (state == cssq_pkg::cssq_ramp |-> !soft_current_high && soft_ramp_en) // [R4]
    else $error("high soft-start current during boot ramp");
  a_clk_en_count: assert property ($fell(clk_enable_b) |-> $past(state == cssq_pkg::cssq_count, 1) &&
    $past(state == cssq_pkg::cssq_count, 13) && !$past(state == cssq_pkg::cssq_count, 14)) // [R5]
    else $error("clock-enable not released after 13 settle cycles");
  a_high_current_vid: assert property (!clk_enable_b |-> soft_current_high && target_mv == $past(vid_target_mv)) // [R6]
    else $error("clock-enable asserted without high current and code target");
  a_power_good_out_timing: assert property ($rose(power_good_out) |-> $past(power_good_out_time) && !$past(clk_enable_b)) // [R7]
    else $error("power-good rose early or before the code target");
  a_target_run: assert property (power_good_out && $past(power_good_out) |-> target_mv == $past(vid_target_mv)) // [R8]
    else $error("target does not follow the identification code");
  a_vid_endpoints: assert property ((voltage_id_code == 7'h00 |-> vid_target_mv == 14'h3A98) and
    (voltage_id_code == 7'h01 |-> vid_target_mv == 14'h3A1B)) // [R9]
    else $error("code 0 or 1 decoded to the wrong voltage");
  a_vid_binary: assert property (voltage_id_code < 7'h78 |->
    vid_target_mv == 14'(14'h3A98 - 14'h007D * {7'h00, voltage_id_code})) // [R10]
    else $error("identification code bit order wrong");
  a_abandon_idle: assert property (!regulator_enable_in |=> state == cssq_pkg::cssq_idle && clk_enable_b &&
    !power_good_out) // [R11]
    else $error("enable low did not abandon the sequence");
  // a sagging control supply is treated exactly like enable going low
  a_supply_loss_idle: assert property (!supply_above_por |=> state == cssq_pkg::cssq_idle && !power_good_out) // [R11]
    else $error("supply loss did not abandon the sequence");
  a_delay_no_ramp: assert property (state == cssq_pkg::cssq_delay |-> !soft_ramp_en && clk_enable_b) // [R2]
    else $error("ramp or clock-enable active during the start delay");
  a_count_low_current: assert property (state == cssq_pkg::cssq_count |-> !soft_current_high && clk_enable_b) // [R4]
    else $error("high soft-start current before clock-enable");
  a_power_good_out_run_only: assert property (power_good_out |-> state == cssq_pkg::cssq_run) // [R7]
    else $error("power-good high outside the run state");
  a_boot_target_hold: assert property (clk_enable_b |-> target_mv == cssq_pkg::BOOT_MV) // [R2]
    else $error("target left boot level before clock-enable");
  a_run_stays: assert property (state == cssq_pkg::cssq_run && go_on |=> state == cssq_pkg::cssq_run) // [R8]
    else $error("run state left while enabled");

  c_power_good_out_rise: cover property ($rose(power_good_out));
  c_clk_en_fall: cover property ($fell(clk_enable_b));
  c_abandon_ramp: cover property (state == cssq_pkg::cssq_ramp ##1 state == cssq_pkg::cssq_idle);
  c_sleep_mode: cover property (diode_emulation_en);
  // the top codes floor at zero rather than wrapping
  c_code_floor: cover property (voltage_id_code >= cssq_pkg::VID_ZERO_CODE && vid_target_mv == cssq_pkg::ZERO_MV);
endmodule

// ---- bench/cssq_supply_model.sv ----
// supply side model: sensed output follows the soft-start reference
`timescale 1ns/100ps
module cssq_supply_model (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic soft_ramp_en,
  input wire logic soft_current_high,
  input wire logic [13:0] target_mv,
  output logic [13:0] output_voltage_sense
);
  // slow slew on the low current, five times faster on the high one
  logic [13:0] step;
  assign step = soft_current_high ? 14'h0028 : 14'h0008;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      output_voltage_sense <= 14'h0000;
    end else if (!soft_ramp_en) begin
      output_voltage_sense <= 14'h0000;
    end else if (output_voltage_sense + step <= target_mv) begin
      output_voltage_sense <= output_voltage_sense + step;
    end else if (output_voltage_sense >= target_mv + step) begin
      output_voltage_sense <= output_voltage_sense - step;
    end else begin
      output_voltage_sense <= target_mv;
    end
  end
endmodule

// ---- bench/cssq_sequencer_tb.sv ----
// self-checking bench for the start-up sequencer
`timescale 1ns/100ps
module cssq_sequencer_tb;
  localparam int PG = 6000;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic regulator_enable_in = 1'b0;
  logic supply_above_por = 1'b0;
  logic sleep_request = 1'b0;
  logic diode_emulation_request = 1'b0;
  logic [6:0] voltage_id_code = 7'h00;
  logic [13:0] output_voltage_sense, target_mv;
  logic forced_continuous_conduction, diode_emulation_en, soft_ramp_en, soft_current_high;
  logic clk_enable_b, power_good_out;
  logic [6:0] corner [11] = '{7'h00, 7'h01, 7'h02, 7'h04, 7'h08, 7'h10, 7'h20, 7'h40, 7'h77, 7'h78, 7'h7F};
  int errors = 0;
  int compares = 0;
  int seed = 32'h01FC;
  int cyc = 0;
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;
  cssq_sequencer #(.POWER_GOOD_OUT_CYCLES(PG)) dut_u (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .regulator_enable_in(regulator_enable_in),
    .supply_above_por(supply_above_por),
    .output_voltage_sense(output_voltage_sense),
    .voltage_id_code(voltage_id_code),
    .sleep_request(sleep_request),
    .diode_emulation_request(diode_emulation_request),
    .forced_continuous_conduction(forced_continuous_conduction),
    .diode_emulation_en(diode_emulation_en),
    .soft_ramp_en(soft_ramp_en),
    .soft_current_high(soft_current_high),
    .target_mv(target_mv),
    .clk_enable_b(clk_enable_b),
    .power_good_out(power_good_out)
  );
  cssq_supply_model model_u (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .soft_ramp_en(soft_ramp_en),
    .soft_current_high(soft_current_high),
    .target_mv(target_mv),
    .output_voltage_sense(output_voltage_sense)
  );
  task automatic end_sim();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [13:0] seen, input logic [13:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic timeout(input string what);
    errors++;
    $display("CHECK FAILED %s expected done seen timeout", what);
    end_sim();
  endtask
  // bounded wait, sampled on the falling edge where outputs have settled
  task automatic wait_for(input string what, ref logic sig, input logic val, input int lim);
    int k = 0;
    while (sig !== val) begin
      @(negedge core_clk);
      k++;
      if (k > lim) timeout(what);
    end
  endtask
  function automatic logic [13:0] exp_mv(input logic [6:0] c);
    return (c < 7'h78) ? 14'h3A98 - 14'h007D * 14'(c) : 14'h0000;
  endfunction
  task automatic start_up(input logic [6:0] code);
    int t0;
    int t1;
    int k = 0;
    @(posedge core_clk);
    t0 = cyc;
    regulator_enable_in <= 1'b1;
    voltage_id_code <= code;
    // requests high during start-up must not leave forced conduction
    sleep_request <= 1'b1;
    diode_emulation_request <= 1'($random(seed));
    wait_for("ramp start", soft_ramp_en, 1'b1, 4100);
    // enable is sampled one edge after it is driven, then the delay runs
    check("ramp start time", 14'(cyc - t0 - 2), 14'(cssq_pkg::START_DELAY_CYC));
    check("low current", 14'(soft_current_high), 14'h0000);
    while (output_voltage_sense < 14'h2E18 || output_voltage_sense > 14'h2FA8) begin
      @(negedge core_clk);
      k++;
      if (k > 3000) timeout("near boot");
    end
    t1 = cyc;
    wait_for("clock enable", clk_enable_b, 1'b0, 40);
    // one edge for the design to see the settled sense, then the count
    check("clock enable delay", 14'(cyc - t1), 14'(cssq_pkg::CLK_EN_COUNT + 1));
    check("high current", 14'(soft_current_high), 14'h0001);
    check("startup conduction", 14'(forced_continuous_conduction), 14'h0001);
    check("startup target", target_mv, exp_mv(code));
    wait_for("power good", power_good_out, 1'b1, PG);
    check("power good time", 14'(cyc - t0 >= PG + 1 && cyc - t0 <= PG + 5), 14'h0001);
  endtask
  initial begin
    logic [6:0] c;
    repeat (2) @(posedge core_clk);
    check("reset clock enable", 14'(clk_enable_b), 14'h0001);
    check("reset target", target_mv, 14'h2EE0);
    rst_b <= 1'b1;
    @(posedge core_clk);
    regulator_enable_in <= 1'b1;
    repeat (20) @(negedge core_clk);
    check("no supply start", 14'(soft_ramp_en), 14'h0000);
    @(posedge core_clk);
    supply_above_por <= 1'b1;
    repeat (20) @(negedge core_clk);
    check("no rise start", 14'(soft_ramp_en), 14'h0000);
    @(posedge core_clk);
    regulator_enable_in <= 1'b0;
    start_up(7'h0C);
    for (int i = 0; i < 40; i++) begin
      @(posedge core_clk);
      c = (i < 11) ? corner[i] : 7'($random(seed));
      voltage_id_code <= c;
      sleep_request <= 1'($random(seed));
      repeat (2) @(negedge core_clk);
      check("code target", target_mv, exp_mv(c));
      check("run conduction", 14'(forced_continuous_conduction), 14'(!(sleep_request | diode_emulation_request)));
      check("run diode emulation", 14'(diode_emulation_en), 14'(sleep_request | diode_emulation_request));
    end
    @(posedge core_clk);
    regulator_enable_in <= 1'b0;
    repeat (2) @(negedge core_clk);
    check("abandon power good", 14'(power_good_out), 14'h0000);
    check("abandon clock enable", 14'(clk_enable_b), 14'h0001);
    check("abandon ramp", 14'(soft_ramp_en), 14'h0000);
    start_up(7'h2A);
    end_sim();
  end
endmodule
